// ==== rtl/tmreo_regs.vh ====
/*
 Register offsets, field positions, reset values and count-source figures for the
 event counter / one-shot timer channel.
 Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
*/
`ifndef TMREO_REGS_VH
`define TMREO_REGS_VH

`define TMREO_ADDR_W 4
`define TMREO_OFF_MODE 4'h0
`define TMREO_OFF_START 4'h4
`define TMREO_OFF_TIMER 4'h8
`define TMREO_OFF_STATUS 4'hc

`define TMREO_MODE_RESET 32'h00000000
`define TMREO_TIMER_RESET 16'h0000

`define TMREO_MODE_OP_LO 0
`define TMREO_MODE_OP_HI 1
`define TMREO_MODE_PULSE_BIT 2
`define TMREO_MODE_EXTTRG_BIT 3
`define TMREO_MODE_SRC_LO 4
`define TMREO_MODE_SRC_HI 6
`define TMREO_MODE_TWOPH_BIT 7
`define TMREO_MODE_UP_BIT 8

`define TMREO_OP_EVENT 2'h1
`define TMREO_OP_ONESHOT 2'h2

`define TMREO_START_BIT 0
`define TMREO_START_TRIG_BIT 1

`define TMREO_STAT_RUN_BIT 0
`define TMREO_STAT_OUT_BIT 1
`define TMREO_STAT_DONE_BIT 2

`define TMREO_SRC_F1 3'h0
`define TMREO_SRC_F2 3'h1
`define TMREO_SRC_F16 3'h2
`define TMREO_SRC_F64 3'h3
`define TMREO_SRC_F512 3'h4
`define TMREO_SRC_F4096 3'h5
`define TMREO_PRESC_W 12

`define TMREO_UNDERFLOW_READ 16'hffff
`define TMREO_OVERFLOW_READ 16'h0000

`define TMREO_RESP_OKAY 2'h0
`define TMREO_RESP_SLVERR 2'h2

`endif

// ==== rtl/tmreo_timer.v ====
/*
 One timer channel: event counter mode (pulse output, two-phase counting) and
 one-shot pulse mode, with its registers on an AXI4-Lite slave.
 Assumes all pin inputs are synchronous-domain levels sampled on aclk and that an
 external pad joins the output pin's three signals into one wire.
*/
// Behaviour
// - Pulse output select forces the output pin to drive, ignoring port direction; the code drops pulse output while two-phase is enabled.
// - With pulse output in event mode, output toggles on every underflow or overflow.
// - Pulse output is held low while the count start bit is 0.
// - Two-phase counting is enabled only when its select bit is 1.
// - Two-phase counts 90-degree inputs; normal or quadruple kind fixed per timer.
// - Normal: count up on phase A rise while phase B is high.
// - Normal: count down on phase A fall while B high; nothing else counts.
// - Quadruple: four edge/level combinations count up.
// - Quadruple: the four opposite combinations count down.
// - Timers without event counter mode do not offer it.
// - Event mode reads give live count, FFFF/0000 at reload, written value when idle.
// - Direction control, pulse output and two-phase share the pin; one at a time.
// - One-shot: each trigger drives output high for n count-source periods.
// - One-shot count source is clock divided by 1, 2, 16, 64, 512 or 4096.
// - One-shot counts down; at zero it reloads and stops.
// - A trigger during counting reloads the counter and counting continues.
// - Trigger source internal or external by software; accepted only with start at 1.
// - Clearing the start bit stops one-shot counting.
// - One-shot raises the interrupt request when counting stops.
// - One-shot timer register reads are undefined.
// - One-shot write loads reload and counter when stopped, reload only while counting.
`timescale 1ns/1ps
`include "tmreo_regs.vh"

module tmreo_timer #(
   parameter TWO_PHASE_KIND = 0, // 0 none, 1 normal, 2 quadruple
   parameter EVENT_MODE_EN = 1 // 0 for timers without event counter mode
) (
   input wire aclk, // system clock, 125 MHz
   input wire aresetn, // synchronous reset, active low
   input wire [3:0] s_axi_awaddr, // write address
   input wire [2:0] s_axi_awprot, // unused protection bits
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte strobes
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [3:0] s_axi_araddr, // read address
   input wire [2:0] s_axi_arprot, // unused protection bits
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   input wire timer_input_pin, // trigger, event input, phase A
   input wire timer_output_pin_i, // level seen on output pin, phase B
   output reg timer_output_pin_o, // level driven on output pin
   output wire timer_output_pin_oe_n, // low while this block drives the pin
   input wire port_dir_out, // port direction bit for the pin, 1 = output
   input wire port_data_out, // port data bit for the pin when used as I/O
   output reg irq_req // one-cycle interrupt request
);

   reg [31:0] mode_reg;
   reg start_reg;
   reg [15:0] reload_reg;
   reg [15:0] cnt_reg;
   reg running_reg;
   reg done_reg;
   reg toggle_reg;
   reg rl_flag_reg;
   reg [15:0] rl_val_reg;
   reg [`TMREO_PRESC_W-1:0] presc_reg;
   reg [2:0] a_sync_reg;
   reg [2:0] b_sync_reg;
   reg bvalid_next;

   wire [1:0] op_mode = mode_reg[`TMREO_MODE_OP_HI:`TMREO_MODE_OP_LO];
   wire ev_mode = (EVENT_MODE_EN != 0) && (op_mode == `TMREO_OP_EVENT);
   wire os_mode = (op_mode == `TMREO_OP_ONESHOT);
   wire two_ph = ev_mode && (TWO_PHASE_KIND != 0) && mode_reg[`TMREO_MODE_TWOPH_BIT];
   // Two-phase owns the pin as an input, so pulse output yields to it.
   wire pulse_sel = ev_mode && mode_reg[`TMREO_MODE_PULSE_BIT] && !two_ph;
   wire [2:0] src_sel = mode_reg[`TMREO_MODE_SRC_HI:`TMREO_MODE_SRC_LO];

   // One aligned word: lane-merge helper for partial writes.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] din;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (strb[i])
               merge[i*8 +: 8] = din[i*8 +: 8];
         end
      end
   endfunction

   // Count-source enable: divide by 1, 2, 16, 64, 512 or 4096 from a free prescaler.
   function src_tick;
      input [2:0] sel;
      input [`TMREO_PRESC_W-1:0] p;
      begin
         case (sel)
            `TMREO_SRC_F1: src_tick = 1'b1;
            `TMREO_SRC_F2: src_tick = &p[0:0];
            `TMREO_SRC_F16: src_tick = &p[3:0];
            `TMREO_SRC_F64: src_tick = &p[5:0];
            `TMREO_SRC_F512: src_tick = &p[8:0];
            `TMREO_SRC_F4096: src_tick = &p[11:0];
            default: src_tick = 1'b0;
         endcase
      end
   endfunction

   wire tick = src_tick(src_sel, presc_reg);

   // Edges come from the second and third stages only; the first stage is a pure
   // synchroniser flop.
   wire a_lvl = a_sync_reg[1];
   wire b_lvl = b_sync_reg[1];
   wire a_rise = a_sync_reg[1] & ~a_sync_reg[2];
   wire a_fall = ~a_sync_reg[1] & a_sync_reg[2];
   wire b_rise = b_sync_reg[1] & ~b_sync_reg[2];
   wire b_fall = ~b_sync_reg[1] & b_sync_reg[2];

   reg ev_up;
   reg ev_dn;
   always @*
   begin
      ev_up = 1'b0;
      ev_dn = 1'b0;
      if (two_ph && TWO_PHASE_KIND == 1)
      begin
         ev_up = a_rise & b_lvl;
         ev_dn = a_fall & b_lvl;
      end
      else if (two_ph && TWO_PHASE_KIND == 2)
      begin
         ev_up = (a_rise & b_lvl) | (a_fall & ~b_lvl) | (b_rise & ~a_lvl) | (b_fall & a_lvl);
         ev_dn = (a_fall & b_lvl) | (a_rise & ~b_lvl) | (b_rise & a_lvl) | (b_fall & ~a_lvl);
      end
      else if (ev_mode)
      begin
         ev_up = a_rise & mode_reg[`TMREO_MODE_UP_BIT];
         ev_dn = a_rise & ~mode_reg[`TMREO_MODE_UP_BIT];
      end
   end

   // Bus write: address and data are taken together, one write in flight.
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   wire wr_mode = wr_go && (s_axi_awaddr == `TMREO_OFF_MODE);
   wire wr_start = wr_go && (s_axi_awaddr == `TMREO_OFF_START);
   wire wr_timer = wr_go && (s_axi_awaddr == `TMREO_OFF_TIMER);
   wire wr_stat = wr_go && (s_axi_awaddr == `TMREO_OFF_STATUS);
   wire wr_ok = wr_mode | wr_start | wr_timer | wr_stat;
   wire [31:0] start_word = merge({31'h00000000, start_reg}, s_axi_wdata, s_axi_wstrb);
   wire [31:0] timer_word = merge({16'h0000, reload_reg}, s_axi_wdata, s_axi_wstrb);
   wire start_next = wr_start ? start_word[`TMREO_START_BIT] : start_reg;
   wire int_trig = wr_start && start_word[`TMREO_START_TRIG_BIT];

   wire ext_sel = mode_reg[`TMREO_MODE_EXTTRG_BIT];
   wire trig = os_mode && start_reg && (ext_sel ? a_fall : int_trig);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         a_sync_reg <= 3'h0;
         b_sync_reg <= 3'h0;
         presc_reg <= 12'h000;
      end
      else
      begin
         a_sync_reg <= {a_sync_reg[1:0], timer_input_pin};
         b_sync_reg <= {b_sync_reg[1:0], timer_output_pin_i};
         presc_reg <= presc_reg + 12'h001;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_reg <= `TMREO_MODE_RESET;
         start_reg <= 1'b0;
      end
      else
      begin
         if (wr_mode)
            mode_reg <= merge(mode_reg, s_axi_wdata, s_axi_wstrb);
         start_reg <= start_next;
      end
   end

   reg os_stop;
   always @*
   begin
      os_stop = 1'b0;
      if (os_mode && running_reg)
      begin
         if (!start_reg)
            os_stop = 1'b1;
         // Stopping on the tick after zero keeps the high time at n periods, not n-1.
         else if (!trig && tick && cnt_reg == 16'h0000)
            os_stop = 1'b1;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reload_reg <= `TMREO_TIMER_RESET;
         cnt_reg <= `TMREO_TIMER_RESET;
         running_reg <= 1'b0;
         toggle_reg <= 1'b0;
         rl_flag_reg <= 1'b0;
         rl_val_reg <= 16'h0000;
         irq_req <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         rl_flag_reg <= 1'b0;
         irq_req <= os_stop;
         if (os_stop)
            done_reg <= 1'b1;
         else if (wr_stat && s_axi_wstrb[0] && s_axi_wdata[`TMREO_STAT_DONE_BIT])
            done_reg <= 1'b0;
         if (wr_timer)
            reload_reg <= timer_word[15:0];
         if (os_mode)
         begin
            toggle_reg <= 1'b0;
            if (trig)
            begin
               // A zero width gives no pulse; a new trigger reloads and goes on.
               cnt_reg <= wr_timer ? timer_word[15:0] : reload_reg;
               running_reg <= start_reg && ((wr_timer ? timer_word[15:0] : reload_reg) != 16'h0000);
            end
            else if (os_stop)
            begin
               cnt_reg <= wr_timer ? timer_word[15:0] : reload_reg;
               running_reg <= 1'b0;
            end
            else if (wr_timer && !running_reg)
               cnt_reg <= timer_word[15:0];
            else if (running_reg && tick)
               cnt_reg <= cnt_reg - 16'h0001;
         end
         else
         begin
            running_reg <= ev_mode && start_reg;
            if (!start_reg)
               toggle_reg <= 1'b0;
            if (wr_timer && !start_reg)
               cnt_reg <= timer_word[15:0];
            else if (ev_mode && start_reg && (ev_up ^ ev_dn))
            begin
               if (ev_up && cnt_reg == 16'hffff)
               begin
                  cnt_reg <= reload_reg;
                  rl_flag_reg <= 1'b1;
                  rl_val_reg <= `TMREO_OVERFLOW_READ;
                  toggle_reg <= ~toggle_reg;
               end
               else if (ev_dn && cnt_reg == 16'h0000)
               begin
                  cnt_reg <= reload_reg;
                  rl_flag_reg <= 1'b1;
                  rl_val_reg <= `TMREO_UNDERFLOW_READ;
                  toggle_reg <= ~toggle_reg;
               end
               else if (ev_up)
                  cnt_reg <= cnt_reg + 16'h0001;
               else
                  cnt_reg <= cnt_reg - 16'h0001;
            end
         end
         // Leaving event mode drops its running state, so a one-shot never starts untriggered.
         if (wr_mode && !os_mode)
            running_reg <= 1'b0;
      end
   end

   // Pin ownership: pulse output or one-shot drive it; two-phase keeps it an input; otherwise the port decides.
   wire drive_pin = pulse_sel || os_mode || (!two_ph && port_dir_out);
   assign timer_output_pin_oe_n = ~drive_pin;

   always @(posedge aclk)
   begin
      if (!aresetn)
         timer_output_pin_o <= 1'b0;
      else if (os_mode)
         timer_output_pin_o <= running_reg && !os_stop;
      else if (pulse_sel)
         timer_output_pin_o <= toggle_reg && start_next;
      else
         timer_output_pin_o <= port_data_out;
   end

   // Write response one cycle after the take.
   always @*
   begin
      bvalid_next = s_axi_bvalid;
      if (wr_go)
         bvalid_next = 1'b1;
      else if (s_axi_bready)
         bvalid_next = 1'b0;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TMREO_RESP_OKAY;
      end
      else
      begin
         s_axi_bvalid <= bvalid_next;
         if (wr_go)
            s_axi_bresp <= wr_ok ? `TMREO_RESP_OKAY : `TMREO_RESP_SLVERR;
      end
   end

   // Read: the live count is sampled at the take; at a reload instant the
   // reload marker wins so software sees the wrap value.
   assign s_axi_arready = s_axi_arvalid & ~s_axi_rvalid;
   reg [31:0] rd_word;
   reg rd_ok;
   always @*
   begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `TMREO_OFF_MODE: rd_word = mode_reg;
         `TMREO_OFF_START: rd_word = {31'h00000000, start_reg};
         `TMREO_OFF_TIMER: rd_word = {16'h0000, rl_flag_reg ? rl_val_reg : cnt_reg};
         `TMREO_OFF_STATUS: rd_word = {29'h00000000, done_reg, timer_output_pin_o, running_reg};
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TMREO_RESP_OKAY;
      end
      else if (s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? `TMREO_RESP_OKAY : `TMREO_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule // tmreo_timer

// ==== tb/tmreo_checker_assertions.sv ====
/* Checker on the tmreo_timer ports: bus answers, pin drive and one-shot stop.
   Assumes whole-word register writes, which the mode and start shadows follow. */
`timescale 1ns/1ps
module tmreo_checker #(
   parameter TWO_PHASE_KIND = 0
) (
   input wire aclk, // clock
   input wire aresetn, // reset, active low
   input wire [3:0] s_axi_awaddr, // write address
   input wire [31:0] s_axi_wdata, // write data
   input wire s_axi_awvalid, // address valid
   input wire s_axi_wvalid, // data valid
   input wire s_axi_bvalid, // response valid
   input wire s_axi_bready, // response ready
   input wire [3:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read valid
   input wire s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read ready
   input wire [1:0] s_axi_rresp, // read response
   input wire timer_output_pin_o, // pin level
   input wire timer_output_pin_oe_n, // pin enable, low drives
   input wire irq_req // stop request
);
   reg [8:0] mode_reg;
   reg start_reg;
   wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire one_shot = mode_reg[1:0] == 2'h2;
   wire two_ph = mode_reg[1:0] == 2'h1 && mode_reg[7] && TWO_PHASE_KIND != 0;
   wire ev_pulse = mode_reg[1:0] == 2'h1 && mode_reg[2] && !two_ph;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // The shadows update with the design's own registers, so properties allow settling cycles.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_reg <= 9'h000;
         start_reg <= 1'b0;
      end
      else if (wr_take && s_axi_awaddr == 4'h0)
         mode_reg <= s_axi_wdata[8:0];
      else if (wr_take && s_axi_awaddr == 4'h4)
         start_reg <= s_axi_wdata[0];
   end
   property p_wr_answer; wr_take |=> s_axi_bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
   property p_wr_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_wr_done: assert property (p_wr_done) else $error("write answer repeated");
   property p_rd_answer; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
   property p_rd_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rd_done: assert property (p_rd_done) else $error("read answer repeated");
   property p_rd_unmapped;
      s_axi_arvalid && !s_axi_rvalid && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == 2'h2;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read accepted");
   property p_pin_drive; ev_pulse[*2] |-> !timer_output_pin_oe_n; endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("pulse pin not driven");
   property p_pin_input; two_ph[*2] |-> timer_output_pin_oe_n; endproperty
   a_pin_input: assert property (p_pin_input) else $error("two-phase pin driven");
   property p_stop_low; ((one_shot || ev_pulse) && !start_reg)[*3] |-> !timer_output_pin_o;
   endproperty
   a_stop_low: assert property (p_stop_low) else $error("output high while stopped");
   property p_irq_stop; one_shot && $fell(timer_output_pin_o) |-> ##[0:2] irq_req; endproperty
   a_irq_stop: assert property (p_irq_stop) else $error("no request at stop");
   property p_irq_pulse; irq_req |=> !irq_req; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("request too long");
endmodule // tmreo_checker

// ==== tb/tmreo_encoder.sv ====
/* Far-side model: a two-phase encoder and a trigger or event source on the pins.
   Assumes the bench resolves the shared output pin from the block's enable. */
`timescale 1ns/1ps
module tmreo_encoder (
   input wire aclk, // bench clock
   output reg phase_a, // drives the input pin
   output reg phase_b // drives the shared pin while the block lets go
);
   integer pos = 1;
   initial
   begin
      phase_a = 1'b1;
      phase_b = 1'b1;
   end
   // One call is a quarter cycle, so only one phase changes at a time.
   task step(input integer dir, input integer gap);
   begin
      @(posedge aclk);
      pos = (pos + dir + 4) % 4;
      phase_a <= pos == 1 || pos == 2;
      phase_b <= pos < 2;
      repeat (gap) @(posedge aclk);
   end
   endtask
   // The falling edge triggers a one-shot; the rising edge is an event count.
   task pulse(input integer low);
   begin
      @(posedge aclk);
      phase_a <= 1'b0;
      repeat (low) @(posedge aclk);
      phase_a <= 1'b1;
   end
   endtask
endmodule // tmreo_encoder

// ==== tb/tb_tmreo_timer.sv ====
/* Bench for tmreo_timer: registers over AXI4-Lite, pulse output, one-shot and two-phase.
   Assumes the encoder model and the checker files are compiled beforehand. */
`timescale 1ns/1ps
`include "tmreo_regs.vh"
module tb_tmreo_timer;
   logic aclk = 1'b0, aresetn = 1'b0, port_dir_out = 1'b1, port_data_out = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic timer_output_pin_o, timer_output_pin_oe_n, irq_req, timer_input_pin, phase_b;
   wire timer_output_pin_i = timer_output_pin_oe_n ? phase_b : timer_output_pin_o;
   integer fails = 0, n_checks = 0, hi = 0, irqs = 0, h0 = 0, q0 = 0, i;
   integer divs [0:5] = '{'h1, 'h2, 'h10, 'h40, 'h200, 'h1000};
   always #4 aclk = ~aclk;
   tmreo_timer #(.TWO_PHASE_KIND(2), .EVENT_MODE_EN(1)) u_tmreo_timer (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .timer_input_pin, .timer_output_pin_i, .timer_output_pin_o,
      .timer_output_pin_oe_n, .port_dir_out, .port_data_out, .irq_req);
   tmreo_encoder u_tmreo_encoder (.aclk, .phase_a(timer_input_pin), .phase_b);
   // Running totals let a pulse be measured even when it starts inside a bus access.
   always @(posedge aclk)
   begin
      hi <= hi + (timer_output_pin_o === 1'b1);
      irqs <= irqs + (irq_req === 1'b1);
   end
   task complete_run;
   begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] up, input string m);
   begin
      n_checks++;
      if ((got >= lo && got <= up) !== 1'b1)
      begin
         fails++;
         $display("CHECK FAILED %0t %s got %0h", $time, m, got);
      end
   end
   endtask
   task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
   begin
      if (wr)
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
      end
      else
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
      end
      do @(posedge aclk); while ((wr ? s_axi_awready && s_axi_wready : s_axi_arready) !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
      rd = s_axi_rdata;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
   end
   endtask
   task measure(input integer lo, input integer up);
   begin
      while (hi == h0 || timer_output_pin_o === 1'b1) @(posedge aclk);
      repeat (3) @(posedge aclk);
      chk(hi - h0, lo, up, "pulse width");
      chk(irqs - q0, 1, 1, "stop request");
      h0 = hi;
      q0 = irqs;
   end
   endtask
   initial
   begin
      #400000;
      fails++;
      $display("CHECK FAILED %0t watchdog", $time);
      complete_run;
   end
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      acc(1'b0, `TMREO_OFF_MODE, 32'h0);
      chk(rd, `TMREO_MODE_RESET, `TMREO_MODE_RESET, "mode reset");
      acc(1'b0, 4'h2, 32'h0);
      chk(rsp, `TMREO_RESP_SLVERR, `TMREO_RESP_SLVERR, "unmapped read");
      acc(1'b1, 4'h2, 32'h0);
      chk(rsp, `TMREO_RESP_SLVERR, `TMREO_RESP_SLVERR, "unmapped write");
      chk(timer_output_pin_oe_n, 0, 0, "port direction");
      port_dir_out <= 1'b0;
      $display("registers done");
      acc(1'b1, `TMREO_OFF_MODE, 32'h5);
      chk(rsp, `TMREO_RESP_OKAY, `TMREO_RESP_OKAY, "write response");
      acc(1'b1, `TMREO_OFF_TIMER, 32'h0);
      acc(1'b1, `TMREO_OFF_START, 32'h1);
      for (i = 0; i < 3; i++)
      begin
         u_tmreo_encoder.pulse(2);
         repeat (6) @(posedge aclk);
         chk(timer_output_pin_o, ~i & 1, ~i & 1, "underflow toggle");
      end
      chk(timer_output_pin_oe_n, 0, 0, "pulse drive");
      acc(1'b1, `TMREO_OFF_START, 32'h0);
      repeat (3) @(posedge aclk);
      chk(timer_output_pin_o, 0, 0, "stopped low");
      $display("pulse output done");
      acc(1'b1, `TMREO_OFF_START, 32'h1);
      h0 = hi;
      q0 = irqs;
      for (i = 0; i < 6; i++)
      begin
         acc(1'b1, `TMREO_OFF_MODE, 32'h6 | (i << 4));
         acc(1'b1, `TMREO_OFF_TIMER, 32'h2);
         acc(1'b1, `TMREO_OFF_START, 32'h3);
         // Two source periods, plus up to one period of skew from trigger to first tick.
         measure(2 * divs[i], 3 * divs[i] - 1);
      end
      acc(1'b0, `TMREO_OFF_STATUS, 32'h0);
      chk(rd[2], 1, 1, "done flag");
      acc(1'b1, `TMREO_OFF_MODE, 32'h6);
      acc(1'b1, `TMREO_OFF_TIMER, 32'h64);
      acc(1'b1, `TMREO_OFF_START, 32'h3);
      acc(1'b1, `TMREO_OFF_TIMER, 32'h7);
      measure('h64, 'h64);
      acc(1'b1, `TMREO_OFF_START, 32'h3);
      measure(7, 7);
      acc(1'b1, `TMREO_OFF_MODE, 32'he);
      u_tmreo_encoder.pulse(2);
      u_tmreo_encoder.pulse(2);
      measure(9, 11);
      acc(1'b1, `TMREO_OFF_MODE, 32'h6);
      acc(1'b1, `TMREO_OFF_START, 32'h3);
      acc(1'b1, `TMREO_OFF_START, 32'h0);
      measure(1, 6);
      acc(1'b1, `TMREO_OFF_START, 32'h2);
      repeat (20) @(posedge aclk);
      chk(hi - h0, 0, 0, "trigger while stopped");
      $display("one-shot done");
      acc(1'b1, `TMREO_OFF_MODE, 32'h81);
      acc(1'b1, `TMREO_OFF_TIMER, 32'h1234);
      acc(1'b0, `TMREO_OFF_TIMER, 32'h0);
      chk(rd[15:0], 16'h1234, 16'h1234, "written value");
      acc(1'b1, `TMREO_OFF_START, 32'h1);
      chk(timer_output_pin_oe_n, 1, 1, "pin released");
      for (i = 0; i < 4; i++)
         u_tmreo_encoder.step(1, 4 + 8 * i);
      acc(1'b0, `TMREO_OFF_TIMER, 32'h0);
      chk(rd[15:0], 16'h1238, 16'h1238, "count up");
      for (i = 0; i < 6; i++)
         u_tmreo_encoder.step(-1, 4);
      acc(1'b0, `TMREO_OFF_TIMER, 32'h0);
      chk(rd[15:0], 16'h1232, 16'h1232, "count down");
      $display("two-phase done");
      complete_run;
   end
endmodule // tb_tmreo_timer
bind tmreo_timer tmreo_checker #(.TWO_PHASE_KIND(TWO_PHASE_KIND)) u_tmreo_checker (.aclk,
   .aresetn, .s_axi_awaddr, .s_axi_wdata, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp,
   .timer_output_pin_o, .timer_output_pin_oe_n, .irq_req);
